// [logic/dual_comparator_monitor_filter.sv]
// Purpose: Digital side of comparator channels 1 and 3 with shared pin filters.
// Assumes: APB slave with zero wait states; pin inputs synchronous to mclk.
// Notes:   Comparator outputs are asynchronous and pass two flip-flops first.
`timescale 1ns/1ps
module dual_comparator_monitor_filter
  import cmp_monitor_pkg::*;
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Comparator outputs from the analog block
  input  wire logic         cmpRaw1,
  input  wire logic         cmpRaw3,
  // External interrupt pins
  input  wire logic         pinLevel0,
  input  wire logic         pinLevel1,
  input  wire logic         pinLevel3,
  // Interrupt controller side
  output logic              irqOut,
  output irq_link_type      irqLink
);

  monitor_state_type st_q;
  monitor_state_type st_d;

  logic [8:0]        regIdx;
  logic [8:0]        ctlOff;
  logic [1:0]        ctlSel;
  logic              wordOk;
  logic              isCtl;
  logic              hit;
  logic              doWrite;
  logic [7:0]        wByte;
  logic [7:0]        rdByte;
  logic [1:0]        cmpNow;
  logic [NUM_IN-1:0] src;
  logic [NUM_IN-1:0] tick;
  logic [NUM_IN-1:0] lvlNext;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] fall;
  logic [NUM_IN-1:0] edgeHit;
  logic [NUM_IN-1:0] setEv;
  logic [NUM_IN-1:0] spur;
  logic [NUM_IN-1:0] w1c;
  logic [1:0]        sel;
  logic [2:0]        smp;

  assign regIdx  = paddr[10:2];
  assign wordOk  = (paddr[1:0] == 2'h0) && !paddr[11];
  assign ctlOff  = regIdx - IDX_INT_CTL_BASE;
  assign ctlSel  = ctlOff[1:0];
  assign isCtl   = (regIdx >= IDX_INT_CTL_BASE) && (regIdx <= IDX_INT_CTL_LAST);
  assign hit     = wordOk && (isCtl || regIdx == IDX_CMP_CONTROL || regIdx == IDX_EDGE_ENABLE
                   || regIdx == IDX_FILTER_SELECT || regIdx == IDX_IRQ_STATUS
                   || regIdx == IDX_IRQ_MASK);
  assign doWrite = psel && penable && pwrite && hit && pstrb[0];
  assign wByte   = pwdata[7:0];

  always_comb begin
    st_d    = st_q;
    rdByte  = 8'h00;
    tick    = '0;
    lvlNext = st_q.level;
    rise    = '0;
    fall    = '0;
    edgeHit = '0;
    setEv   = '0;
    spur    = '0;
    w1c     = '0;
    sel     = FILT_NONE;
    smp     = 3'h0;

    st_d.syncA    = {cmpRaw3, cmpRaw1};
    st_d.syncB    = st_q.syncA;
    st_d.prescale = st_q.prescale + 5'h01;

    cmpNow = {st_q.cmpCtl[CMP3_RUN_BIT] & st_q.syncB[1],
              st_q.cmpCtl[CMP1_RUN_BIT] & st_q.syncB[0]};

    src = {st_q.cmpCtl[CMP3_RUN_BIT] ? cmpNow[1] : pinLevel3,
           st_q.cmpCtl[CMP1_RUN_BIT] ? cmpNow[0] : pinLevel1,
           pinLevel0};

    // Register read data is captured in the setup cycle.
    case (regIdx)
      IDX_CMP_CONTROL:   rdByte = {cmpNow[1], st_q.cmpCtl[6:4], cmpNow[0], st_q.cmpCtl[2:0]};
      IDX_EDGE_ENABLE:   rdByte = st_q.edgeEn;
      IDX_FILTER_SELECT: rdByte = st_q.filtSel;
      IDX_IRQ_STATUS:    rdByte = {5'h00, st_q.pend};
      IDX_IRQ_MASK:      rdByte = {5'h00, st_q.mask};
      default:           rdByte = isCtl ? {3'h0, st_q.intCtl[ctlSel]} : 8'h00;
    endcase
    if (psel && !penable) begin
      st_d.rdata  = hit ? {24'h000000, rdByte} : 32'h00000000;
      st_d.slvErr = !hit;
    end

    // Writes take effect at the access edge.
    if (doWrite) begin
      case (regIdx)
        IDX_CMP_CONTROL:   st_d.cmpCtl = wByte & CMP_CTL_WMASK;
        IDX_EDGE_ENABLE: begin
          st_d.edgeEn = wByte;
          for (int k = 0; k < NUM_IN; k++) begin
            spur[k] = wByte[IN_BASE[k]] &&
                      (wByte[IN_BASE[k] +: 2] != st_q.edgeEn[IN_BASE[k] +: 2]);
          end
        end
        IDX_FILTER_SELECT: st_d.filtSel = wByte;
        IDX_IRQ_STATUS:    w1c = wByte[NUM_IN-1:0];
        IDX_IRQ_MASK:      st_d.mask = wByte[NUM_IN-1:0];
        default:           st_d.intCtl[ctlSel] = wByte[4:0];
      endcase
    end

    for (int k = 0; k < NUM_IN; k++) begin
      sel = st_q.filtSel[IN_BASE[k] +: 2];
      case (sel)
        FILT_F1:  tick[k] = 1'b1;
        FILT_F8:  tick[k] = (st_q.prescale & F8_MASK) == F8_MASK;
        FILT_F32: tick[k] = (st_q.prescale & F32_MASK) == F32_MASK;
        default:  tick[k] = 1'b0;
      endcase
      smp = {st_q.samples[k][1:0], src[k]};
      if (sel == FILT_NONE) begin
        st_d.samples[k] = {3{src[k]}};
        lvlNext[k]      = src[k];
      end else if (tick[k]) begin
        st_d.samples[k] = smp;
        if (smp == 3'h0 || smp == 3'h7) begin
          lvlNext[k] = src[k];
        end
      end
      st_d.level[k] = lvlNext[k];

      rise[k] = lvlNext[k] & ~st_q.level[k];
      fall[k] = ~lvlNext[k] & st_q.level[k];
      edgeHit[k] = st_q.edgeEn[IN_BASE[k] + 1] ? (rise[k] | fall[k])
                 : (st_q.intCtl[k][INTCTL_SENSE_BIT] ? rise[k] : fall[k]);
      setEv[k] = st_q.edgeEn[IN_BASE[k]] & edgeHit[k];
    end

    st_d.pend = (st_q.pend & ~w1c) | setEv | spur;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q         <= '0;
      st_q.cmpCtl  <= REG_RESET;
      st_q.edgeEn  <= REG_RESET;
      st_q.filtSel <= REG_RESET;
      st_q.intCtl  <= {NUM_IN{INTCTL_RESET}};
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata  = st_q.rdata;
  assign pready  = 1'b1;
  assign pslverr = st_q.slvErr;
  assign irqOut  = |(st_q.pend & st_q.mask);

  always_comb begin
    irqLink.pending = st_q.pend;
    for (int k = 0; k < NUM_IN; k++) begin
      irqLink.level[k] = st_q.intCtl[k][2:0];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_result_off_zero: assert property (
    !st_q.cmpCtl[CMP1_RUN_BIT] |-> !cmpNow[0] && !st_q.cmpCtl[CMP1_RESULT_BIT])
    else $error("Disabled channel 1 shows a result.");

  a_result_sync_delay: assert property (
    st_q.cmpCtl[CMP3_RUN_BIT] && $past(st_q.cmpCtl[CMP3_RUN_BIT]) |-> cmpNow[1] == $past(cmpRaw3, 2))
    else $error("Channel 3 result is not the input two cycles back.");

  a_run_bit_write: assert property (
    doWrite && regIdx == IDX_CMP_CONTROL |=> st_q.cmpCtl[CMP3_RUN_BIT] == $past(wByte[4]))
    else $error("Run enable write was not stored.");

  a_unfiltered_pass: assert property (
    st_q.filtSel[3:2] == FILT_NONE && $stable(st_q.filtSel) |-> st_q.level[1] == $past(src[1]))
    else $error("Unfiltered level does not follow its source.");

  a_filter_three: assert property (
    $changed(st_q.level[2]) && $past(st_q.filtSel[7:6]) != FILT_NONE
      |-> st_q.samples[2] == {3{st_q.level[2]}})
    else $error("Filtered level changed without three matches.");

  // In a filtered mode the history only moves on a tick, so a moved history dates the tick.
  a_f8_tick: assert property (
    $past(st_q.filtSel[3:2]) == FILT_F8 && $changed(st_q.samples[1])
      |-> $past(st_q.prescale[2:0]) == 3'h7)
    else $error("Eighth-rate sample taken off its tick.");

  a_both_edge_req: assert property (
    st_q.edgeEn[2] && st_q.edgeEn[3] && lvlNext[1] != st_q.level[1] |=> st_q.pend[1])
    else $error("Both-edge change gave no request.");

  a_no_req_disabled: assert property (
    $rose(st_q.pend[1]) |-> $past(st_q.edgeEn[2]) || $past(spur[1]))
    else $error("Request raised while input 1 disabled.");

  a_spurious_write: assert property (
    doWrite && regIdx == IDX_EDGE_ENABLE && wByte[6] && !st_q.edgeEn[6] |=> st_q.pend[2])
    else $error("Enabling input 3 did not set its flag.");

  a_set_beats_clear: assert property (
    setEv[0] && w1c[0] |=> st_q.pend[0])
    else $error("Clear beat a simultaneous event.");

  a_irq_level: assert property (
    $rose(st_q.pend[2]) && st_q.mask[2] |-> irqOut)
    else $error("Unmasked request did not raise the interrupt.");

  a_result1_sync: assert property (
    st_q.cmpCtl[CMP1_RUN_BIT] && $past(st_q.cmpCtl[CMP1_RUN_BIT]) |-> cmpNow[0] == $past(cmpRaw1, 2))
    else $error("Channel 1 result is not the input two cycles back.");

  a_result3_off: assert property (
    !st_q.cmpCtl[CMP3_RUN_BIT] |-> !cmpNow[1])
    else $error("Disabled channel 3 shows a result.");

  a_run1_write: assert property (
    doWrite && regIdx == IDX_CMP_CONTROL |=> st_q.cmpCtl[CMP1_RUN_BIT] == $past(wByte[0]))
    else $error("Channel 1 run enable write was not stored.");

  a_edge_en_write: assert property (
    doWrite && regIdx == IDX_EDGE_ENABLE |=> st_q.edgeEn == $past(wByte))
    else $error("Edge enable write was not stored.");

  a_filt_write: assert property (
    doWrite && regIdx == IDX_FILTER_SELECT |=> st_q.filtSel == $past(wByte))
    else $error("Filter select write was not stored.");

  a_f1_tick: assert property (
    st_q.filtSel[3:2] == FILT_F1 && $stable(st_q.filtSel) |-> st_q.samples[1][0] == $past(src[1]))
    else $error("Full-rate filter missed a sample.");

  a_f32_tick: assert property (
    $past(st_q.filtSel[7:6]) == FILT_F32 && $changed(st_q.samples[2])
      |-> $past(st_q.prescale) == 5'h1F)
    else $error("Slowest-rate sample taken off its tick.");

  a_no_req_off3: assert property (
    $rose(st_q.pend[2]) |-> $past(st_q.edgeEn[6]) || $past(spur[2]))
    else $error("Request raised while input 3 disabled.");

  // A falling edge with rising sense in one-edge mode must stay silent.
  a_rise_only: assert property (
    !st_q.edgeEn[3] && st_q.intCtl[1][INTCTL_SENSE_BIT] && fall[1] && !st_q.pend[1] && !spur[1]
      |=> !st_q.pend[1])
    else $error("Falling edge raised a rising-sense request.");

  a_unfiltered3: assert property (
    st_q.filtSel[7:6] == FILT_NONE && $stable(st_q.filtSel) |-> st_q.level[2] == $past(src[2]))
    else $error("Unfiltered input 3 does not follow its source.");

  a_shared_src: assert property (
    !st_q.cmpCtl[CMP1_RUN_BIT] |-> src[1] == pinLevel1)
    else $error("Input 1 filter does not watch its pin.");

  a_w1c_clear: assert property (
    doWrite && regIdx == IDX_IRQ_STATUS && wByte[1] && !setEv[1] && !spur[1] |=> !st_q.pend[1])
    else $error("Writing one did not clear the pending flag.");

  a_set_beats_clr3: assert property (
    setEv[2] && w1c[2] |=> st_q.pend[2])
    else $error("Clear beat a simultaneous input 3 event.");

  // Each flag moves only through its own set, spurious or clear term.
  a_pend1_hold: assert property (
    !setEv[1] && !spur[1] && !w1c[1] |=> st_q.pend[1] == $past(st_q.pend[1]))
    else $error("Input 1 flag moved without its own cause.");

  a_pend3_hold: assert property (
    !setEv[2] && !spur[2] && !w1c[2] |=> st_q.pend[2] == $past(st_q.pend[2]))
    else $error("Input 3 flag moved without its own cause.");

  a_unmapped_err: assert property (
    psel && !penable && !hit |=> pslverr && prdata == 32'h00000000)
    else $error("Unmapped access gave no error.");

  a_rdata_high_zero: assert property (
    prdata[31:8] == 24'h000000)
    else $error("Read data has bits above the low byte.");

  a_level_link: assert property (
    irqLink.level[2] == st_q.intCtl[2][2:0])
    else $error("Input 3 priority level not on the link.");

  c_f32_change: cover property (st_q.filtSel[7:6] == FILT_F32 ##1 $changed(st_q.level[2]));
  c_irq_raised: cover property ($rose(irqOut));
  c_spur_set: cover property (spur[1] ##1 st_q.pend[1]);
  c_f8_change: cover property (st_q.filtSel[3:2] == FILT_F8 ##1 $changed(st_q.level[1]));
  c_pin_source: cover property (!st_q.cmpCtl[CMP1_RUN_BIT] && setEv[1]);

endmodule : dual_comparator_monitor_filter

// [logic/cmp_monitor_pkg.sv]
// Purpose: Constants and types shared by the dual comparator monitor filter.
// Assumes: APB byte address is four times the register index.
// Notes:   Inputs are ordered 0, 1, 3 in every three-wide vector.
package cmp_monitor_pkg;

  // Register indexes; the byte address is four times the index.
  localparam logic [8:0] IDX_CMP_CONTROL   = 9'h1F8;
  localparam logic [8:0] IDX_EDGE_ENABLE   = 9'h1FA;
  localparam logic [8:0] IDX_FILTER_SELECT = 9'h1FC;
  localparam logic [8:0] IDX_IRQ_STATUS    = 9'h1F0;
  localparam logic [8:0] IDX_IRQ_MASK      = 9'h1F1;
  localparam logic [8:0] IDX_INT_CTL_BASE  = 9'h1F4;
  localparam logic [8:0] IDX_INT_CTL_LAST  = 9'h1F6;

  // Comparator control fields.
  localparam int         CMP1_RUN_BIT    = 0;
  localparam int         CMP1_RESULT_BIT = 3;
  localparam int         CMP3_RUN_BIT    = 4;
  localparam int         CMP3_RESULT_BIT = 7;
  localparam logic [7:0] CMP_CTL_WMASK   = 8'h77;

  // Inputs 0, 1 and 3 use the same bit base in edge enable and filter select.
  localparam int         NUM_IN          = 3;
  localparam int         IN_BASE [NUM_IN] = '{0, 2, 6};

  // Interrupt control fields: priority level and edge sense.
  localparam int         INTCTL_SENSE_BIT = 4;

  // Reset values.
  localparam logic [7:0] REG_RESET    = 8'h00;
  localparam logic [4:0] INTCTL_RESET = 5'h00;

  // Filter select codes and sampling divider masks.
  localparam logic [1:0] FILT_NONE = 2'h0;
  localparam logic [1:0] FILT_F1   = 2'h1;
  localparam logic [1:0] FILT_F8   = 2'h2;
  localparam logic [1:0] FILT_F32  = 2'h3;
  localparam logic [4:0] F8_MASK   = 5'h07;
  localparam logic [4:0] F32_MASK  = 5'h1F;

  // Comparator settling time that software must wait.
  localparam int SETTLE_TIME_US = 100;
  localparam int CLK_MHZ        = 20;
  localparam int SETTLE_CYCLES  = SETTLE_TIME_US * CLK_MHZ;

  // Link to the interrupt controller.
  typedef struct packed {
    logic [NUM_IN-1:0]      pending;
    logic [NUM_IN-1:0][2:0] level;
  } irq_link_type;

  // Whole state of the monitor.
  typedef struct packed {
    logic [7:0]             cmpCtl;
    logic [7:0]             edgeEn;
    logic [7:0]             filtSel;
    logic [NUM_IN-1:0]      pend;
    logic [NUM_IN-1:0]      mask;
    logic [NUM_IN-1:0][4:0] intCtl;
    logic [1:0]             syncA;
    logic [1:0]             syncB;
    logic [4:0]             prescale;
    logic [NUM_IN-1:0][2:0] samples;
    logic [NUM_IN-1:0]      level;
    logic [31:0]            rdata;
    logic                   slvErr;
  } monitor_state_type;

endpackage : cmp_monitor_pkg

// [bench/irq_ctrl_model.sv]
// Purpose: Interrupt controller model on the far side of the request link.
// Assumes: A higher priority level wins and ties go to the lower input.
// Notes:   Winner 3 means that no request is pending.
`timescale 1ns/1ps
module irq_ctrl_model
  import cmp_monitor_pkg::*;
(
  // Request link
  input  wire irq_link_type irqLink,
  // Selected source
  output logic [1:0]        winner
);
  logic [2:0] best;

  always_comb begin
    winner = 2'h3;
    best   = 3'h0;
    for (int k = 0; k < NUM_IN; k++) begin
      if (irqLink.pending[k] && (winner == 2'h3 || irqLink.level[k] > best)) begin
        winner = k[1:0];
        best   = irqLink.level[k];
      end
    end
  end
endmodule : irq_ctrl_model

// [bench/dual_comparator_monitor_filter_tb.sv]
// Purpose: Self-checking bench for the dual comparator monitor filter.
// Assumes: Zero-wait APB slave and a 20 MHz clock.
// Notes:   Filter cases use glitches one sample period long.
`timescale 1ns/1ps
module dual_comparator_monitor_filter_tb
  import cmp_monitor_pkg::*;
;
  logic         mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irqOut, err;
  logic         cmpRaw1, cmpRaw3, pinLevel0, pinLevel1, pinLevel3;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd;
  logic [3:0]   pstrb;
  logic [1:0]   winner;
  irq_link_type irqLink;
  int           fail_count, checked, p;

  dual_comparator_monitor_filter dual_comparator_monitor_filter_i (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmpRaw1(cmpRaw1), .cmpRaw3(cmpRaw3), .pinLevel0(pinLevel0),
    .pinLevel1(pinLevel1), .pinLevel3(pinLevel3), .irqOut(irqOut), .irqLink(irqLink)
  );

  irq_ctrl_model irq_ctrl_model_i (.irqLink(irqLink), .winner(winner));

  always #25 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    apb(1'b1, {1'b0, idx, 2'h0}, d);
  endtask : wr

  task automatic rc(input logic [8:0] idx, input logic [31:0] e);
    apb(1'b0, {1'b0, idx, 2'h0}, 8'h0);
    chk(rd, e);
  endtask : rc

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    {mclk, psel, penable, pwrite, paddr, pwdata, fail_count, checked} = '0;
    {cmpRaw1, cmpRaw3, pinLevel0, pinLevel1, pinLevel3} = '0;
    sys_rst = 1'b1;
    pstrb   = 4'hF;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rc(IDX_CMP_CONTROL, 32'h0);
    rc(IDX_EDGE_ENABLE, 32'h0);
    rc(IDX_FILTER_SELECT, 32'h0);
    apb(1'b0, 12'h7E1, 8'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    cmpRaw1 <= 1'b1;
    cmpRaw3 <= 1'b1;
    cyc(4);
    rc(IDX_CMP_CONTROL, 32'h0);
    wr(IDX_CMP_CONTROL, 8'hFF);
    cyc(3);
    rc(IDX_CMP_CONTROL, 32'hFF);
    cmpRaw1 <= 1'b0;
    cyc(3);
    rc(IDX_CMP_CONTROL, 32'hF7);
    $display("test result done");
    cyc(SETTLE_CYCLES);
    wr(IDX_EDGE_ENABLE, 8'h04);
    wr(IDX_INT_CTL_BASE + 9'h1, 8'h15);
    wr(IDX_IRQ_STATUS, 8'h07);
    wr(IDX_IRQ_MASK, 8'h07);
    chk({29'h0, irqLink.level[1]}, 32'h5);
    cmpRaw1 <= 1'b1;
    cyc(6);
    rc(IDX_IRQ_STATUS, 32'h2);
    chk({31'h0, irqOut}, 32'h1);
    chk({30'h0, winner}, 32'h1);
    wr(IDX_IRQ_MASK, 8'h00);
    cyc(2);
    chk({31'h0, irqOut}, 32'h0);
    wr(IDX_IRQ_STATUS, 8'h02);
    cmpRaw1 <= 1'b0;
    cyc(6);
    rc(IDX_IRQ_STATUS, 32'h0);
    wr(IDX_INT_CTL_BASE + 9'h1, 8'h05);
    wr(IDX_EDGE_ENABLE, 8'h0C);
    rc(IDX_IRQ_STATUS, 32'h2);
    for (int e = 0; e < 2; e++) begin
      wr(IDX_IRQ_STATUS, 8'h07);
      cmpRaw1 <= ~cmpRaw1;
      cmpRaw3 <= ~cmpRaw3;
      cyc(6);
      rc(IDX_IRQ_STATUS, 32'h2);
    end
    $display("test edge done");
    for (int c = 1; c < 4; c++) begin
      p = (c == 1) ? 1 : (c == 2) ? 8 : 32;
      wr(IDX_FILTER_SELECT, {4'h0, c[1:0], 2'h0});
      wr(IDX_IRQ_STATUS, 8'h07);
      cmpRaw1 <= ~cmpRaw1;
      cyc(p);
      cmpRaw1 <= ~cmpRaw1;
      cyc(4 * p + 8);
      rc(IDX_IRQ_STATUS, 32'h0);
      cmpRaw1 <= ~cmpRaw1;
      cyc(4 * p + 8);
      rc(IDX_IRQ_STATUS, 32'h2);
    end
    $display("test filter done");
    wr(IDX_CMP_CONTROL, 8'h10);
    cyc(140);
    wr(IDX_IRQ_STATUS, 8'h07);
    pinLevel1 <= 1'b1;
    cyc(140);
    rc(IDX_IRQ_STATUS, 32'h2);
    $display("test pin done");
    print_verdict();
  end
endmodule : dual_comparator_monitor_filter_tb
